// ==== design/channel_proc_pkg.sv ====
// Constants shared by the analog channel processing block
package channel_proc_pkg;
   localparam logic [5:0] REG_CODE_WORD = 6'h1F;
   localparam logic [5:0] REG_FEATURE = 6'h20;
   localparam logic [5:0] REG_SCALE_OFFSET = 6'h21;
   localparam logic [5:0] REG_SCALE_GAIN = 6'h22;
   localparam logic [5:0] REG_THRESH_ONE = 6'h23;
   localparam logic [5:0] REG_THRESH_TWO = 6'h24;
   localparam logic [5:0] REG_CUTOFF = 6'h25;

   localparam logic [15:0] FEATURE_RST = 16'h0906;
   localparam logic [15:0] SCALE_OFFSET_RST = 16'h0000;
   localparam logic [15:0] SCALE_GAIN_RST = 16'h0400;
   localparam logic [15:0] THRESH_RST = 16'h0000;
   localparam logic [15:0] CUTOFF_RST = 16'h0100;
   localparam logic [15:0] CODE_WORD_RST = 16'h0000;
   localparam logic [15:0] UNLOCK_CODE = 16'h1235;
   localparam logic [15:0] FACTORY_OFFSET_RST = 16'h0000;
   localparam logic [15:0] FACTORY_GAIN_RST = 16'h2000;
   localparam logic [15:0] UPPER_LIMIT_RST = 16'h0FFF;
   localparam logic [15:0] LOWER_LIMIT_RST = 16'h0000;

   localparam int FB_LOWPASS = 11;
   localparam int FB_THRESH_TWO = 10;
   localparam int FB_THRESH_ONE = 9;
   localparam int FB_RANGE_CLAMP = 8;
   localparam int FB_PACKED = 4;
   localparam int FB_SIGN_MAG = 3;
   localparam int FB_WATCHDOG = 2;
   localparam int FB_FACTORY_OFF = 1;
   localparam int FB_CUSTOM = 0;

   localparam int CTRL_REG_ON = 7;
   localparam int CTRL_WRITE = 6;

   localparam int ST_UNDER = 0;
   localparam int ST_OVER = 1;
   localparam int ST_T1_BELOW = 2;
   localparam int ST_T1_ABOVE = 3;
   localparam int ST_T2_BELOW = 4;
   localparam int ST_T2_ABOVE = 5;
   localparam int ST_WATCHDOG = 6;

   localparam logic [2:0] PK_OK = 3'h0;
   localparam logic [2:0] PK_OVERFLOW = 3'h1;
   localparam logic [2:0] PK_WIRE_BREAK = 3'h3;

   localparam logic [15:0] CUT_CODE_1 = 16'h0100;
   localparam logic [15:0] CUT_CODE_2 = 16'h0200;
   localparam logic [15:0] CUT_CODE_3 = 16'h0300;
   localparam logic [15:0] CUT_CODE_4 = 16'h0400;
   localparam logic [2:0] CUT_SHIFT_1 = 3'h2;
   localparam logic [2:0] CUT_SHIFT_2 = 3'h3;
   localparam logic [2:0] CUT_SHIFT_3 = 3'h4;
   localparam logic [2:0] CUT_SHIFT_4 = 3'h6;

   localparam int CUSTOM_GAIN_FRAC = 10;
   localparam int FACTORY_GAIN_FRAC = 10;

   localparam int CLK_FREQ_HZ = 20000000;
   localparam int WDOG_TIME_MS = 100;
   localparam int WDOG_CYCLES = WDOG_TIME_MS * (CLK_FREQ_HZ / 1000);
endpackage

// ==== design/lowpass_stage.sv ====
// First-order recursive low-pass stage for one channel
`timescale 1ns/1ps
`default_nettype none
module lowpass_stage #(
   parameter int W = 16
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic signed [W-1:0] sample_in,
   input wire logic sample_valid_in,
   input wire logic filter_on_in,
   input wire logic [2:0] shift_in,
   output logic signed [W-1:0] filt_out,
   output logic filt_valid_out
);
   typedef struct packed {
      logic signed [W-1:0] acc;
      logic valid;
      logic primed;
   } lp_state_t;

   lp_state_t st_ff;
   lp_state_t nxt_st;
   logic signed [W:0] diff;

   if (W < 4) begin : g_bad_width
      $error("lowpass_stage: width too small");
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.valid = sample_valid_in;
      diff = (W+1)'(sample_in) - (W+1)'(st_ff.acc);
      if (sample_valid_in) begin
         // Bypass also reloads, so enabling later starts without a step
         if (!filter_on_in || shift_in == 3'h0 || !st_ff.primed) begin
            nxt_st.acc = sample_in;
         end else begin
            nxt_st.acc = st_ff.acc + W'(diff >>> shift_in);
         end
         nxt_st.primed = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign filt_out = st_ff.acc;
   assign filt_valid_out = st_ff.valid;
endmodule // lowpass_stage
`default_nettype wire

// ==== design/analog_channel.sv ====
// One analog input channel: scaling, limiting, filtering and register access
`timescale 1ns/1ps
`default_nettype none
module analog_channel
   import channel_proc_pkg::*;
#(
   parameter int WDOG_LIMIT = channel_proc_pkg::WDOG_CYCLES,
   parameter bit LIVE_ZERO = 1'b0,
   parameter logic [15:0] FACTORY_OFFSET = channel_proc_pkg::FACTORY_OFFSET_RST,
   parameter logic [15:0] FACTORY_GAIN = channel_proc_pkg::FACTORY_GAIN_RST,
   parameter logic [15:0] UPPER_LIMIT = channel_proc_pkg::UPPER_LIMIT_RST,
   parameter logic [15:0] LOWER_LIMIT = channel_proc_pkg::LOWER_LIMIT_RST
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic signed [15:0] sample_in,
   input wire logic sample_valid_in,
   input wire logic [7:0] ctrl_byte_in,
   input wire logic [15:0] host_word_in,
   input wire logic pd_received_in,
   output logic [7:0] status_byte_out,
   output logic [15:0] data_word_out,
   output logic watchdog_expired_out
);
   import channel_proc_pkg::*;

   localparam int WDW = $clog2(WDOG_LIMIT + 1);

   if (WDOG_LIMIT < 2) begin : g_bad_wdog
      $error("analog_channel: watchdog limit too small");
   end
   if (signed'(LOWER_LIMIT) > signed'(UPPER_LIMIT)) begin : g_bad_limits
      $error("analog_channel: lower range limit above upper");
   end

   typedef struct packed {
      logic [15:0] feature;
      logic [15:0] scale_offset;
      logic [15:0] scale_gain;
      logic [15:0] thresh_one;
      logic [15:0] thresh_two;
      logic [15:0] cutoff;
      logic [15:0] code_word;
      logic meas_over;
      logic meas_under;
      logic clamp_over;
      logic clamp_under;
      logic [15:0] pd_word;
      logic [7:0] chan_status;
      logic [7:0] status_out;
      logic [15:0] data_out;
      logic [WDW-1:0] wdog_cnt;
      logic wdog_hit;
   } chan_state_t;

   chan_state_t st_ff;
   chan_state_t nxt_st;

   logic signed [15:0] factory_val;
   logic signed [15:0] custom_val;
   logic signed [15:0] limited_val;
   logic signed [15:0] filt_val;
   logic filt_valid;
   logic [2:0] filt_shift;
   logic filt_on;
   logic [15:0] signed_word;
   logic [15:0] formatted;
   logic [7:0] new_status;
   logic reg_on;
   logic reg_write;
   logic [5:0] reg_num;
   logic unlocked;

   // Saturate a wide intermediate to the 16-bit signed range
   function automatic logic [15:0] sat16(input logic signed [33:0] v);
      logic [15:0] r;
      r = v[15:0];
      if (v > 34'sd32767) begin
         r = 16'h7FFF;
      end else if (v < -34'sd32768) begin
         r = 16'h8000;
      end
      return r;
   endfunction

   // Fixed-point gain then offset, shared by factory and custom scaling
   function automatic logic [15:0] scale16(
      input logic signed [15:0] x,
      input logic signed [15:0] gain,
      input logic signed [15:0] offs,
      input int frac
   );
      logic signed [33:0] p;
      p = 34'(x) * 34'(gain);
      p = p >>> frac;
      p = p + 34'(offs);
      return sat16(p);
   endfunction

   // Raw range tests, shared by the clamp and the packed status flags
   function automatic logic over_range(input logic signed [15:0] v);
      return v > signed'(UPPER_LIMIT);
   endfunction

   function automatic logic under_range(input logic signed [15:0] v);
      return v < signed'(LOWER_LIMIT);
   endfunction

   // Both directions reported; equal to the threshold raises neither
   function automatic logic [1:0] thresh_bits(
      input logic signed [15:0] v,
      input logic [15:0] limit
   );
      logic [1:0] b;
      b[0] = v < signed'(limit);
      b[1] = v > signed'(limit);
      return b;
   endfunction

   function automatic logic [2:0] cut_shift(input logic [15:0] code);
      logic [2:0] s;
      case (code)
         CUT_CODE_1: s = CUT_SHIFT_1;
         CUT_CODE_2: s = CUT_SHIFT_2;
         CUT_CODE_3: s = CUT_SHIFT_3;
         CUT_CODE_4: s = CUT_SHIFT_4;
         default: s = 3'h0;
      endcase
      return s;
   endfunction

   function automatic logic [15:0] reg_read(
      input chan_state_t s,
      input logic [5:0] idx
   );
      logic [15:0] r;
      case (idx)
         REG_CODE_WORD: r = s.code_word;
         REG_FEATURE: r = s.feature;
         REG_SCALE_OFFSET: r = s.scale_offset;
         REG_SCALE_GAIN: r = s.scale_gain;
         REG_THRESH_ONE: r = s.thresh_one;
         REG_THRESH_TWO: r = s.thresh_two;
         REG_CUTOFF: r = s.cutoff;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   // Front of the chain, all combinational up to the filter register
   always_comb begin
      if (!st_ff.feature[FB_FACTORY_OFF]) begin
         factory_val = scale16(sample_in, FACTORY_GAIN,
            FACTORY_OFFSET, FACTORY_GAIN_FRAC);
      end else begin
         factory_val = sample_in;
      end
      if (st_ff.feature[FB_CUSTOM]) begin
         custom_val = scale16(factory_val, st_ff.scale_gain,
            st_ff.scale_offset, CUSTOM_GAIN_FRAC);
      end else begin
         custom_val = factory_val;
      end
      limited_val = custom_val;
      if (st_ff.feature[FB_RANGE_CLAMP]) begin
         if (over_range(custom_val)) begin
            limited_val = UPPER_LIMIT;
         end else if (under_range(custom_val)) begin
            limited_val = LOWER_LIMIT;
         end
      end
   end

   // Unknown cut-off codes give shift zero, which bypasses the filter
   assign filt_on = st_ff.feature[FB_LOWPASS];
   assign filt_shift = cut_shift(st_ff.cutoff);

   // Filter sits after the clamp so a spike cannot drag the average
   lowpass_stage #(
      .W(16)
   ) u_lowpass (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .sample_in(limited_val),
      .sample_valid_in(sample_valid_in),
      .filter_on_in(filt_on),
      .shift_in(filt_shift),
      .filt_out(filt_val),
      .filt_valid_out(filt_valid)
   );

   // Back of the chain: thresholds and output word
   always_comb begin
      new_status = 8'h00;
      new_status[ST_UNDER] = st_ff.clamp_under;
      new_status[ST_OVER] = st_ff.clamp_over;
      if (st_ff.feature[FB_THRESH_ONE]) begin
         new_status[ST_T1_ABOVE:ST_T1_BELOW] =
            thresh_bits(filt_val, st_ff.thresh_one);
      end
      if (st_ff.feature[FB_THRESH_TWO]) begin
         new_status[ST_T2_ABOVE:ST_T2_BELOW] =
            thresh_bits(filt_val, st_ff.thresh_two);
      end
      signed_word = filt_val;
      if (st_ff.feature[FB_SIGN_MAG] && filt_val[15]) begin
         // Most negative code has no magnitude form and reads as minus zero
         signed_word = {1'b1, 15'(-filt_val)};
      end
      formatted = signed_word;
      if (st_ff.feature[FB_PACKED]) begin
         if (st_ff.meas_over) begin
            formatted = {13'h0000, PK_OVERFLOW};
         end else if (LIVE_ZERO && st_ff.meas_under) begin
            formatted = {13'h0000, PK_WIRE_BREAK};
         end else begin
            formatted = {signed_word[15:3], PK_OK};
         end
      end
   end

   // Control byte decode; the echo answers every access, refused or not
   assign reg_on = ctrl_byte_in[CTRL_REG_ON];
   assign reg_write = reg_on && ctrl_byte_in[CTRL_WRITE];
   assign reg_num = ctrl_byte_in[5:0];
   assign unlocked = st_ff.code_word == UNLOCK_CODE;

   always_comb begin
      nxt_st = st_ff;
      // Range flags travel with the sample into the filter register
      if (sample_valid_in) begin
         nxt_st.meas_over = over_range(custom_val);
         nxt_st.meas_under = under_range(custom_val);
         nxt_st.clamp_over = st_ff.feature[FB_RANGE_CLAMP]
            && over_range(custom_val);
         nxt_st.clamp_under = st_ff.feature[FB_RANGE_CLAMP]
            && under_range(custom_val);
      end
      if (filt_valid) begin
         nxt_st.pd_word = formatted;
         nxt_st.chan_status[5:0] = new_status[5:0];
      end
      // Watchdog restarts on each host process data word
      if (!st_ff.feature[FB_WATCHDOG] || pd_received_in) begin
         nxt_st.wdog_cnt = '0;
         nxt_st.wdog_hit = 1'b0;
      end else if (st_ff.wdog_cnt == WDW'(WDOG_LIMIT - 1)) begin
         nxt_st.wdog_hit = 1'b1;
      end else begin
         nxt_st.wdog_cnt = st_ff.wdog_cnt + WDW'(1);
      end
      nxt_st.chan_status[ST_WATCHDOG] = nxt_st.wdog_hit;
      nxt_st.chan_status[7] = 1'b0;
      // Register writes repeat while the control byte is held; harmless
      if (reg_write) begin
         if (reg_num == REG_CODE_WORD) begin
            nxt_st.code_word = host_word_in;
         end else if (unlocked) begin
            case (reg_num)
               REG_FEATURE: nxt_st.feature = host_word_in;
               REG_SCALE_OFFSET: nxt_st.scale_offset = host_word_in;
               REG_SCALE_GAIN: nxt_st.scale_gain = host_word_in;
               REG_THRESH_ONE: nxt_st.thresh_one = host_word_in;
               REG_THRESH_TWO: nxt_st.thresh_two = host_word_in;
               REG_CUTOFF: nxt_st.cutoff = host_word_in;
               default: nxt_st.code_word = st_ff.code_word;
            endcase
         end
      end
      if (reg_on) begin
         if (reg_write) begin
            nxt_st.status_out = {ctrl_byte_in[7], 1'b0,
               ctrl_byte_in[5:0]};
            nxt_st.data_out = 16'h0000;
         end else begin
            nxt_st.status_out = ctrl_byte_in;
            nxt_st.data_out = reg_read(st_ff, reg_num);
         end
      end else begin
         nxt_st.status_out = nxt_st.chan_status;
         nxt_st.data_out = nxt_st.pd_word;
      end
   end

   // Constants only in reset; the unlock never survives a restart
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         st_ff <= '0;
         st_ff.feature <= FEATURE_RST;
         st_ff.scale_offset <= SCALE_OFFSET_RST;
         st_ff.scale_gain <= SCALE_GAIN_RST;
         st_ff.thresh_one <= THRESH_RST;
         st_ff.thresh_two <= THRESH_RST;
         st_ff.cutoff <= CUTOFF_RST;
         st_ff.code_word <= CODE_WORD_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign status_byte_out = st_ff.status_out;
   assign data_word_out = st_ff.data_out;
   assign watchdog_expired_out = st_ff.wdog_hit;
endmodule // analog_channel
`default_nettype wire

// ==== test/analog_channel_assertions.sv ====
// Checker for register echo, readback, watchdog timing and held data
`timescale 1ns/1ps
`default_nettype none
module analog_channel_assertions #(
   parameter int WDOG_LIMIT = channel_proc_pkg::WDOG_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic sample_valid_in,
   input wire logic [7:0] ctrl_byte_in,
   input wire logic [15:0] host_word_in,
   input wire logic pd_received_in,
   input wire logic [7:0] status_byte_out,
   input wire logic [15:0] data_word_out,
   input wire logic watchdog_expired_out
);
   import channel_proc_pkg::*;
   logic reg_on, rd_on, wr_on, mapped;
   logic [15:0] code_ff, feat_ff;
   int since_pd_ff;
   assign reg_on = ctrl_byte_in[7];
   assign rd_on = reg_on & ~ctrl_byte_in[6];
   assign wr_on = reg_on & ctrl_byte_in[6];
   assign mapped = ctrl_byte_in[5:0] == REG_CODE_WORD ||
      (ctrl_byte_in[5:0] >= REG_FEATURE && ctrl_byte_in[5:0] <= REG_CUTOFF);
   // Shadows let readback be judged without peeking inside
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         code_ff <= 16'h0000;
         feat_ff <= FEATURE_RST;
         since_pd_ff <= 0;
      end else begin
         if (wr_on && ctrl_byte_in[5:0] == REG_CODE_WORD)
            code_ff <= host_word_in;
         if (wr_on && ctrl_byte_in[5:0] == REG_FEATURE && code_ff == UNLOCK_CODE)
            feat_ff <= host_word_in;
         if (pd_received_in)
            since_pd_ff <= 0;
         else if (since_pd_ff < WDOG_LIMIT)
            since_pd_ff <= since_pd_ff + 1;
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   a_read_echo: assert property (rd_on |=>
      status_byte_out == $past(ctrl_byte_in)) else $error("read echo wrong");
   a_write_echo: assert property (wr_on |=>
      status_byte_out == ($past(ctrl_byte_in) & 8'hBF))
      else $error("write echo wrong");
   a_write_data: assert property (wr_on |=>
      data_word_out == 16'h0000) else $error("write answer word not zero");
   a_unmapped_read: assert property (rd_on && !mapped |=>
      data_word_out == 16'h0000) else $error("unmapped read not zero");
   a_code_readback: assert property (rd_on &&
      ctrl_byte_in[5:0] == REG_CODE_WORD |=> data_word_out == code_ff)
      else $error("code word readback wrong");
   a_feature_readback: assert property (rd_on &&
      ctrl_byte_in[5:0] == REG_FEATURE |=> data_word_out == feat_ff)
      else $error("feature readback wrong");
   a_wdog_restart: assert property (pd_received_in |=>
      !watchdog_expired_out) else $error("watchdog not restarted");
   a_wdog_early: assert property (watchdog_expired_out |->
      since_pd_ff >= WDOG_LIMIT - 1) else $error("watchdog fired early");
   a_wdog_off: assert property (!feat_ff[FB_WATCHDOG] |=>
      !watchdog_expired_out) else $error("disabled watchdog expired");
   a_data_holds: assert property (!$past(reg_on) && !$past(reg_on, 2)
      && !$past(sample_valid_in, 2) |-> $stable(data_word_out))
      else $error("process data changed without a sample");
   c_write: cover property (wr_on);
   c_wdog: cover property ($rose(watchdog_expired_out));
   c_sample: cover property (sample_valid_in ##2 !reg_on);
endmodule // analog_channel_assertions
bind analog_channel analog_channel_assertions #(.WDOG_LIMIT(WDOG_LIMIT))
   u_analog_channel_assertions (.clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in), .sample_valid_in(sample_valid_in),
   .ctrl_byte_in(ctrl_byte_in), .host_word_in(host_word_in),
   .pd_received_in(pd_received_in), .status_byte_out(status_byte_out),
   .data_word_out(data_word_out),
   .watchdog_expired_out(watchdog_expired_out));
`default_nettype wire

// ==== test/coupler_model.sv ====
// Fieldbus coupler model: control byte, output word, data pulse
`timescale 1ns/1ps
`default_nettype none
module coupler_model (
   input wire logic clk_sys_in,
   output logic [7:0] ctrl_byte_out,
   output logic [15:0] host_word_out,
   output logic pd_received_out
);
   initial begin
      ctrl_byte_out = 8'h00;
      host_word_out = 16'h0000;
      pd_received_out = 1'b0;
   end
   // Held from one falling edge to the next, across the sampling edge
   task automatic access(input logic wr, input logic [5:0] num,
         input logic [15:0] word);
      @(negedge clk_sys_in);
      ctrl_byte_out = {1'b1, wr, num};
      host_word_out = word;
   endtask
   // Released word is inverted so a stale value cannot pass
   task automatic idle();
      ctrl_byte_out = 8'h00;
      host_word_out = ~host_word_out;
   endtask
   task automatic pulse_pd();
      @(negedge clk_sys_in);
      pd_received_out = 1'b1;
      @(negedge clk_sys_in);
      pd_received_out = 1'b0;
   endtask
endmodule // coupler_model
`default_nettype wire

// ==== test/analog_input_channel_processing_bench.sv ====
// Self-checking bench for the analog channel with a coupler model
`timescale 1ns/1ps
`default_nettype none
module analog_input_channel_processing_bench;
   import channel_proc_pkg::*;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [15:0] sample_in = 16'h0000;
   logic sample_valid_in = 1'b0;
   logic [7:0] ctrl_byte, status_byte_out;
   logic [15:0] host_word, data_word_out;
   logic pd_received, watchdog_expired_out;
   logic [15:0] live_data_word;
   int error_cnt = 0;
   int compares = 0;
   logic [5:0] rst_num [8] = '{6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24,
      6'h25, 6'h30};
   logic [15:0] rst_val [8] = '{16'h0000, 16'h0906, 16'h0000, 16'h0400,
      16'h0000, 16'h0000, 16'h0100, 16'h0000};
   logic [15:0] cut_code [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400,
      16'h0500};
   logic [15:0] cut_exp [5] = '{16'h0040, 16'h0020, 16'h0010, 16'h0004,
      16'h0100};
   always #25 clk_sys_in = ~clk_sys_in;
   analog_channel #(.WDOG_LIMIT(20)) u_analog_channel (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sample_in(sample_in),
      .sample_valid_in(sample_valid_in), .ctrl_byte_in(ctrl_byte),
      .host_word_in(host_word), .pd_received_in(pd_received),
      .status_byte_out(status_byte_out), .data_word_out(data_word_out),
      .watchdog_expired_out(watchdog_expired_out));
   coupler_model u_coupler_model (.clk_sys_in(clk_sys_in),
      .ctrl_byte_out(ctrl_byte), .host_word_out(host_word),
      .pd_received_out(pd_received));
   // Live-zero variant shares every input; only its packed word differs
   analog_channel #(.WDOG_LIMIT(20), .LIVE_ZERO(1'b1))
      u_analog_channel_live (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sample_in(sample_in),
      .sample_valid_in(sample_valid_in), .ctrl_byte_in(ctrl_byte),
      .host_word_in(host_word), .pd_received_in(pd_received),
      .status_byte_out(), .data_word_out(live_data_word),
      .watchdog_expired_out());
   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wreg(input logic [5:0] num, input logic [15:0] val);
      u_coupler_model.access(1'b1, num, val);
      @(negedge clk_sys_in);
      check("write echo", {8'h00, status_byte_out}, {10'h002, num});
      u_coupler_model.idle();
   endtask
   task automatic rreg(input logic [5:0] num, input logic [15:0] val);
      u_coupler_model.access(1'b0, num, ~val);
      @(negedge clk_sys_in);
      check("read echo", {8'h00, status_byte_out}, {10'h002, num});
      check("read data", data_word_out, val);
      u_coupler_model.idle();
   endtask
   task automatic samp(input logic [15:0] x, input logic [15:0] e,
         input logic [7:0] st);
      @(negedge clk_sys_in);
      sample_in = x;
      sample_valid_in = 1'b1;
      @(negedge clk_sys_in);
      sample_valid_in = 1'b0;
      @(negedge clk_sys_in);
      check("process data", data_word_out, e);
      check("status", {8'h00, status_byte_out}, {8'h00, st});
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      int n;
      repeat (8) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      resetn_in = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rreg(rst_num[i],
            rst_val[i]);
      end
      wreg(REG_FEATURE, 16'h0000);
      rreg(REG_FEATURE, 16'h0906);
      wreg(6'h26, 16'hBEEF);
      rreg(6'h26, 16'h0000);
      u_coupler_model.pulse_pd();
      for (int i = 0; i < 17; i++) begin
         @(negedge clk_sys_in);
         check("watchdog early", {15'h0000, watchdog_expired_out},
            16'h0000);
      end
      n = 0;
      while (watchdog_expired_out !== 1'b1 && n < 5) begin
         @(negedge clk_sys_in);
         n++;
      end
      check("watchdog fired", {15'h0000, watchdog_expired_out},
         16'h0001);
      // A watchdog that never fired ends the run at the report
      if (watchdog_expired_out !== 1'b1) begin
         wrap_up();
      end
      wreg(REG_CODE_WORD, 16'h1235);
      rreg(REG_CODE_WORD, 16'h1235);
      wreg(REG_FEATURE, 16'h0000);
      @(negedge clk_sys_in);
      check("watchdog off", {15'h0000, watchdog_expired_out},
         16'h0000);
      samp(16'h0010, 16'h0080, 8'h00);
      wreg(REG_FEATURE, 16'h0102);
      samp(16'h0123, 16'h0123, 8'h00);
      samp(16'h2000, 16'h0FFF, 8'h02);
      samp(16'hFFFB, 16'h0000, 8'h01);
      wreg(REG_FEATURE, 16'h000A);
      samp(16'hFFFF, 16'h8001, 8'h00);
      samp(16'hFFFB, 16'h8005, 8'h00);
      wreg(REG_FEATURE, 16'h0012);
      samp(16'h1000, 16'h0001, 8'h00);
      check("live zero over", live_data_word, 16'h0001);
      samp(16'h0123, 16'h0120, 8'h00);
      check("live zero range", live_data_word, 16'h0120);
      // Below the lower limit only the live-zero variant drops the data
      samp(16'hFFF0, 16'hFFF0, 8'h00);
      check("live zero break", live_data_word, 16'h0003);
      wreg(REG_SCALE_OFFSET, 16'h0005);
      wreg(REG_FEATURE, 16'h0003);
      samp(16'h0100, 16'h0105, 8'h00);
      wreg(REG_SCALE_GAIN, 16'h0800);
      wreg(REG_SCALE_OFFSET, 16'h0013);
      wreg(REG_FEATURE, 16'h0013);
      samp(16'h0100, 16'h0210, 8'h00);
      wreg(REG_THRESH_ONE, 16'h0100);
      wreg(REG_THRESH_TWO, 16'h0200);
      wreg(REG_FEATURE, 16'h0602);
      samp(16'h0150, 16'h0150, 8'h18);
      samp(16'h0050, 16'h0050, 8'h14);
      samp(16'h0250, 16'h0250, 8'h28);
      wreg(REG_FEATURE, 16'h0402);
      samp(16'h0250, 16'h0250, 8'h20);
      // Bypass first so the filter starts from a known zero
      for (int i = 0; i < 5; i++) begin
         wreg(REG_CUTOFF, cut_code[i]);
         wreg(REG_FEATURE, 16'h0002);
         samp(16'h0000, 16'h0000, 8'h00);
         wreg(REG_FEATURE, 16'h0802);
         samp(16'h0100, cut_exp[i], 8'h00);
      end
      wrap_up();
   end
endmodule // analog_input_channel_processing_bench
`default_nettype wire
